// *** design/swpm_pkg.sv ***
/*
 package for the spin-wait and paired-single merge execute slice.
 assumes one core clock; all pipeline inputs arrive on that clock.
*/
package swpm_pkg;

   // instruction fields
   localparam int OP_HI        = 31;
   localparam int OP_LO        = 26;
   localparam int RS_HI        = 25;
   localparam int RS_LO        = 21;
   localparam int RT_HI        = 20;
   localparam int RT_LO        = 16;
   localparam int RD_HI        = 15;
   localparam int RD_LO        = 11;
   localparam int SA_HI        = 10;
   localparam int SA_LO        = 6;
   localparam int FN_HI        = 5;
   localparam int FN_LO        = 0;

   // encodings
   localparam logic [5:0]  OPC_ORI      = 6'h0d;
   localparam logic [5:0]  OPC_SPECIAL  = 6'h00;
   localparam logic [5:0]  OPC_FPCOP    = 6'h11;
   localparam logic [4:0]  FMT_PS       = 5'h16;
   localparam logic [5:0]  FN_SHIFT_LL  = 6'h00;
   localparam logic [4:0]  SA_SPIN      = 5'h05;
   localparam logic [5:0]  FN_MRG_LL    = 6'h2c;
   localparam logic [5:0]  FN_MRG_LU    = 6'h2d;

   // exception codes
   localparam logic [1:0]  EXC_NONE     = 2'h0;
   localparam logic [1:0]  EXC_RESV     = 2'h1;
   localparam logic [1:0]  EXC_COP_UNU  = 2'h2;

   // register port
   localparam int          ADDR_W       = 4;
   localparam logic [3:0]  ADR_CTRL     = 4'h0;
   localparam logic [3:0]  ADR_STAT     = 4'h4;
   localparam logic [3:0]  ADR_MASK     = 4'h8;
   localparam logic [3:0]  ADR_STATE    = 4'hc;

   // control bits
   localparam int          CTL_SPIN_EN  = 0;
   localparam int          CTL_REV6     = 1;
   localparam int          CTL_MT       = 2;
   localparam int          CTL_PS_EN    = 3;
   localparam logic [3:0]  CTRL_RESET   = 4'h9;

   // event bits
   localparam int          EV_RESV      = 0;
   localparam int          EV_COP_UNU   = 1;
   localparam int          EV_WAIT      = 2;
   localparam int          EV_RELEASE   = 3;
   localparam int          EV_N         = 4;
   localparam logic [3:0]  MASK_RESET   = 4'h0;

   typedef enum logic [0:0] {
      SWPM_RUN  = 1'b0,
      SWPM_WAIT = 1'b1
   } swpm_state_t;

   typedef struct packed {
      logic        valid;
      logic [31:0] word;
      logic        delay_slot;
      logic        forbidden_slot;
      logic [63:0] rs_val;
      logic [63:0] fs_val;
      logic [63:0] ft_val;
   } swpm_instr_t;

   typedef struct packed {
      logic        gpr_we;
      logic [4:0]  gpr_idx;
      logic [63:0] gpr_data;
      logic        fpr_we;
      logic [4:0]  fpr_idx;
      logic [63:0] fpr_data;
   } swpm_wb_t;

   typedef struct packed {
      logic       valid;
      logic [1:0] code;
   } swpm_exc_t;

endpackage

// *** design/swpm_sticky.sv ***
/*
 one sticky event bit.
 assumes set and clear come from logic on the same clock.
*/
`timescale 1ns/1ps
module swpm_sticky (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // event and clear
   input  wire logic set,
   input  wire logic clr,
   // state
   output logic      q
);
   logic q_next;

   // set beats a clear in the same cycle so no event is lost
   assign q_next = set | (q & ~clr);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= 1'b0;
      end else begin
         q <= q_next;
      end
   end
endmodule

// *** design/swpm_merge.sv ***
/*
 paired-single merge datapath, combinational.
 assumes operands are 64-bit register images (64-bit register mode).
*/
`timescale 1ns/1ps
module swpm_merge (
   // operands
   input  wire logic [63:0] src_a,
   input  wire logic [63:0] src_b,
   // select upper half of the second operand
   input  wire logic        take_upper,
   // result
   output logic [63:0]      result
);
   logic [31:0] b_half;

   assign b_half = take_upper ? src_b[63:32] : src_b[31:0];
   // pure move: nothing here feeds any status or flag
   assign result = {src_a[31:0], b_half};
endmodule

// *** design/swpm_exec.sv ***
/*
 decode and execute for or-immediate, spin-wait and the two
 paired-single merge operations, with a small register port.
 assumes the pipeline presents one instruction per valid cycle,
 honours issue_stall, and that ll_set and remote_store come from
 the core's load-linked and coherence logic on the same clock.
*/
`timescale 1ns/1ps

module swpm_exec (
   // clock and reset
   input  wire logic                        clk,
   input  wire logic                        rst,
   // instruction issue
   input  wire swpm_pkg::swpm_instr_t       instr,
   output logic                             issue_stall,
   // core state
   input  wire logic                        fpu_enabled,
   input  wire logic                        ll_set,
   input  wire logic                        remote_store,
   input  wire logic                        ext_event,
   // results
   output swpm_pkg::swpm_wb_t               wb,
   output swpm_pkg::swpm_exc_t              exc,
   output logic                             link_reservation_flag,
   // register port
   input  wire logic [swpm_pkg::ADDR_W-1:0] addr,
   input  wire logic [31:0]                 wr_data,
   input  wire logic                        wr_en,
   input  wire logic                        rd_en,
   output logic [31:0]                      rd_data,
   // interrupt
   output logic                             irq
);
   import swpm_pkg::*;

   // instruction fields
   wire logic [5:0]  f_op;
   wire logic [4:0]  f_rs;
   wire logic [4:0]  f_rt;
   wire logic [4:0]  f_rd;
   wire logic [4:0]  f_sa;
   wire logic [5:0]  f_fn;
   wire logic [63:0] imm_zx;

   assign f_op   = instr.word[OP_HI:OP_LO];
   assign f_rs   = instr.word[RS_HI:RS_LO];
   assign f_rt   = instr.word[RT_HI:RT_LO];
   assign f_rd   = instr.word[RD_HI:RD_LO];
   assign f_sa   = instr.word[SA_HI:SA_LO];
   assign f_fn   = instr.word[FN_HI:FN_LO];
   assign imm_zx = {48'h0000_0000_0000, instr.word[15:0]};

   // registers
   logic [3:0]  ctrl_reg;
   logic [3:0]  mask_reg;
   logic [3:0]  stat_q;
   swpm_state_t state_reg;
   swpm_state_t state_next;
   logic        link_reservation_flag_reg;
   logic        link_reservation_flag_next;
   logic        stall_reg;
   logic        stall_next;
   swpm_wb_t    wb_reg;
   swpm_wb_t    wb_next;
   swpm_exc_t   exc_reg;
   swpm_exc_t   exc_next;
   logic [31:0] rd_reg;
   logic [31:0] rd_next;
   logic        irq_reg;
   logic        irq_next;

   // control fields
   wire logic spin_en;
   wire logic rev6;
   wire logic multi_thread;
   wire logic ps_en;

   assign spin_en      = ctrl_reg[CTL_SPIN_EN];
   assign rev6         = ctrl_reg[CTL_REV6];
   assign multi_thread = ctrl_reg[CTL_MT];
   assign ps_en        = ctrl_reg[CTL_PS_EN];

   // decode; an instruction is only taken while issue runs
   wire logic take;
   wire logic is_ori;
   wire logic is_spin;
   wire logic is_ps;
   wire logic is_mrg_ll;
   wire logic is_mrg_lu;
   wire logic in_slot;

   assign take    = instr.valid & (state_reg == SWPM_RUN);
   assign is_ori  = take & (f_op == OPC_ORI);
   assign is_spin = take & (f_op == OPC_SPECIAL) & (f_rs == 5'h00)
                    & (f_rt == 5'h00) & (f_rd == 5'h00)
                    & (f_sa == SA_SPIN) & (f_fn == FN_SHIFT_LL);
   assign is_ps   = take & (f_op == OPC_FPCOP) & (f_rs == FMT_PS);
   assign is_mrg_ll = is_ps & (f_fn == FN_MRG_LL);
   assign is_mrg_lu = is_ps & (f_fn == FN_MRG_LU);
   assign in_slot = instr.delay_slot | instr.forbidden_slot;

   // exception causes
   wire logic spin_resv;
   wire logic mrg_any;
   wire logic mrg_cop_unu;
   wire logic mrg_resv;
   wire logic mrg_ok;
   wire logic spin_go;

   // older revisions leave slot placement to software
   assign spin_resv   = is_spin & rev6 & in_slot;
   assign mrg_any     = is_mrg_ll | is_mrg_lu;
   assign mrg_cop_unu = mrg_any & ~fpu_enabled;
   assign mrg_resv    = mrg_any & fpu_enabled
                        & (rev6 | ~ps_en);
   assign mrg_ok      = mrg_any & ~mrg_cop_unu & ~mrg_resv;
   // an unimplemented spin-wait falls through as a plain no-op, unless rev6 puts it in a slot
   assign spin_go     = is_spin & spin_en & ~spin_resv;

   // merge datapath
   wire logic [63:0] mrg_result;

   swpm_merge u_merge (
      .src_a      (instr.fs_val),
      .src_b      (instr.ft_val),
      .take_upper (is_mrg_lu),
      .result     (mrg_result)
   );

   // link reservation flag
   // a fresh load-linked wins over a remote store in the same cycle
   assign link_reservation_flag_next = ll_set | (link_reservation_flag_reg & ~remote_store);

   // spin-wait sequencing
   wire logic wake;

   // single-thread waits also end on an external event; a
   // relinquished thread waits for its flag only
   assign wake = ~link_reservation_flag_next
                 | (~multi_thread & ext_event);

   always_comb begin
      state_next = state_reg;
      stall_next = stall_reg;
      case (state_reg)
         SWPM_RUN: begin
            if (spin_go && link_reservation_flag_reg && !wake) begin
               state_next = SWPM_WAIT;
               stall_next = 1'b1;
            end
         end
         SWPM_WAIT: begin
            if (wake) begin
               state_next = SWPM_RUN;
               stall_next = 1'b0;
            end
         end
         default: begin
            state_next = SWPM_RUN;
            stall_next = 1'b0;
         end
      endcase
   end

   // write-back; merges never touch the fp control/status word
   always_comb begin
      wb_next = '0;
      if (is_ori) begin
         wb_next.gpr_we   = 1'b1;
         wb_next.gpr_idx  = f_rt;
         wb_next.gpr_data = instr.rs_val | imm_zx;
      end
      if (mrg_ok) begin
         wb_next.fpr_we   = 1'b1;
         wb_next.fpr_idx  = f_sa;
         wb_next.fpr_data = mrg_result;
      end
   end

   // exceptions; or-immediate and merges raise no arithmetic ones
   always_comb begin
      exc_next = '0;
      if (mrg_cop_unu) begin
         exc_next.valid = 1'b1;
         exc_next.code  = EXC_COP_UNU;
      end else if (spin_resv || mrg_resv) begin
         exc_next.valid = 1'b1;
         exc_next.code  = EXC_RESV;
      end
   end

   // register port decode
   wire logic wr_ctrl;
   wire logic wr_mask;
   wire logic rd_stat;
   wire logic [3:0] ev_set;
   wire logic [3:0] stat_view;

   assign wr_ctrl = wr_en & (addr == ADR_CTRL);
   assign wr_mask = wr_en & (addr == ADR_MASK);
   assign rd_stat = rd_en & (addr == ADR_STAT);

   assign ev_set[EV_RESV]    = spin_resv | mrg_resv;
   assign ev_set[EV_COP_UNU] = mrg_cop_unu;
   assign ev_set[EV_WAIT]    = (state_reg == SWPM_RUN)
                               & (state_next == SWPM_WAIT);
   assign ev_set[EV_RELEASE] = (state_reg == SWPM_WAIT)
                               & (state_next == SWPM_RUN);

   // a status read returns the bits and clears them
   genvar gi;
   generate
      for (gi = 0; gi < EV_N; gi++) begin : g_ev
         swpm_sticky u_bit (
            .clk (clk),
            .rst (rst),
            .set (ev_set[gi]),
            .clr (rd_stat),
            .q   (stat_q[gi])
         );
      end
   endgenerate

   assign stat_view = stat_q;

   always_comb begin
      rd_next = 32'h0000_0000;
      if (rd_en) begin
         if (addr == ADR_CTRL) begin
            rd_next = {28'h000_0000, ctrl_reg};
         end else if (addr == ADR_STAT) begin
            rd_next = {28'h000_0000, stat_view};
         end else if (addr == ADR_MASK) begin
            rd_next = {28'h000_0000, mask_reg};
         end else if (addr == ADR_STATE) begin
            rd_next = {30'h000_0000, link_reservation_flag_reg, stall_reg};
         end else begin
            rd_next = 32'h0000_0000;
         end
      end
   end

   // level interrupt from the sticky bits gated by the mask; it looks
   // at the bits as they will be after this edge so it moves with them
   wire logic [3:0] stat_after;

   assign stat_after = ev_set | (stat_q & {4{~rd_stat}});
   assign irq_next   = |(stat_after & mask_reg);

   // state registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= SWPM_RUN;
         stall_reg <= 1'b0;
         link_reservation_flag_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         stall_reg <= stall_next;
         link_reservation_flag_reg <= link_reservation_flag_next;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= CTRL_RESET;
         mask_reg <= MASK_RESET;
      end else begin
         if (wr_ctrl) begin
            ctrl_reg <= wr_data[3:0];
         end
         if (wr_mask) begin
            mask_reg <= wr_data[3:0];
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wb_reg  <= '0;
         exc_reg <= '0;
         rd_reg  <= 32'h0000_0000;
         irq_reg <= 1'b0;
      end else begin
         wb_reg  <= wb_next;
         exc_reg <= exc_next;
         rd_reg  <= rd_next;
         irq_reg <= irq_next;
      end
   end

   // outputs
   assign issue_stall           = stall_reg;
   assign wb                    = wb_reg;
   assign exc                   = exc_reg;
   assign link_reservation_flag = link_reservation_flag_reg;
   assign rd_data               = rd_reg;
   assign irq                   = irq_reg;

endmodule

// *** bench/swpm_exec_asserts.sv ***
/*
 assertion checker for swpm_exec, bound to its ports.
 assumes the bench keeps issue inputs quiet while reset is high.
*/
`timescale 1ns/1ps
module swpm_exec_asserts (
   // clock and reset
   input wire logic                  clk,
   input wire logic                  rst,
   // issue and core state
   input wire swpm_pkg::swpm_instr_t instr,
   input wire logic                  issue_stall,
   input wire logic                  fpu_enabled,
   input wire logic                  ll_set,
   input wire logic                  remote_store,
   input wire logic                  ext_event,
   // results
   input wire swpm_pkg::swpm_wb_t    wb,
   input wire swpm_pkg::swpm_exc_t   exc,
   input wire logic                  link_reservation_flag
);
   import swpm_pkg::*;
   wire logic       take = instr.valid && !issue_stall;
   wire logic [5:0] fn   = instr.word[5:0];
   wire logic       mrg  = take && instr.word[31:21] == {OPC_FPCOP, FMT_PS}
                           && (fn == FN_MRG_LL || fn == FN_MRG_LU);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   property p_ori;
      take && instr.word[31:26] == OPC_ORI |=> wb.gpr_we && !exc.valid
         && wb.gpr_idx == $past(instr.word[20:16])
         && wb.gpr_data == ($past(instr.rs_val)
                            | {48'h0, $past(instr.word[15:0])});
   endproperty
   a_ori: assert property (p_ori)
      else $error("or-immediate writeback wrong");

   property p_mll;
      mrg && fpu_enabled && fn == FN_MRG_LL |=>
         (exc.valid && exc.code == EXC_RESV && !wb.fpr_we)
         || (wb.fpr_we && !exc.valid
             && wb.fpr_idx == $past(instr.word[10:6])
             && wb.fpr_data == {$past(instr.fs_val[31:0]),
                                $past(instr.ft_val[31:0])});
   endproperty
   a_mll: assert property (p_mll)
      else $error("lower-lower merge wrong");

   property p_mlu;
      mrg && fpu_enabled && fn == FN_MRG_LU |=>
         (exc.valid && exc.code == EXC_RESV && !wb.fpr_we)
         || (wb.fpr_we && !exc.valid
             && wb.fpr_idx == $past(instr.word[10:6])
             && wb.fpr_data == {$past(instr.fs_val[31:0]),
                                $past(instr.ft_val[63:32])});
   endproperty
   a_mlu: assert property (p_mlu)
      else $error("lower-upper merge wrong");

   property p_unusable;
      mrg && !fpu_enabled |=> exc.valid && exc.code == EXC_COP_UNU
         && !wb.fpr_we;
   endproperty
   a_unusable: assert property (p_unusable)
      else $error("disabled fpu merge not refused");

   property p_flag_set;
      ll_set |=> link_reservation_flag;
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("link flag not set");

   property p_flag_clr;
      remote_store && !ll_set |=> !link_reservation_flag;
   endproperty
   a_flag_clr: assert property (p_flag_clr)
      else $error("remote store left link flag set");

   property p_release;
      issue_stall && remote_store && !ll_set |=> !issue_stall;
   endproperty
   a_release: assert property (p_release)
      else $error("remote store did not release wait");

   property p_hold;
      issue_stall && !remote_store && !ext_event |=> $stable(issue_stall);
   endproperty
   a_hold: assert property (p_hold)
      else $error("wait ended without wake");

   property p_quiet;
      issue_stall |=> !(wb.gpr_we || wb.fpr_we);
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("instruction executed while waiting");
endmodule

bind swpm_exec swpm_exec_asserts u_chk (
   .clk                   (clk),
   .rst                   (rst),
   .instr                 (instr),
   .issue_stall           (issue_stall),
   .fpu_enabled           (fpu_enabled),
   .ll_set                (ll_set),
   .remote_store          (remote_store),
   .ext_event             (ext_event),
   .wb                    (wb),
   .exc                   (exc),
   .link_reservation_flag (link_reservation_flag)
);

// *** bench/swpm_exec_test.sv ***
/*
 self-checking bench for swpm_exec: scenario tasks per behaviour.
 assumes the checker file binds itself onto the design.
*/
`timescale 1ns/1ps
module swpm_exec_test;
   import swpm_pkg::*;
   localparam logic [31:0] SPIN_W = 32'h0000_0140;
   localparam logic [31:0] ORI_W  = {OPC_ORI, 5'h03, 5'h07, 16'h8001};
   logic        clk, rst, fpu_enabled, ll_set, remote_store, ext_event;
   logic        issue_stall, link_reservation_flag, wr_en, rd_en, irq;
   swpm_instr_t instr;
   swpm_wb_t    wb;
   swpm_exc_t   exc;
   logic [3:0]  addr;
   logic [31:0] wr_data, rd_data, rv;
   int          n_mismatch, num_checks;

   swpm_exec u_dut (.clk(clk), .rst(rst), .instr(instr),
      .issue_stall(issue_stall), .fpu_enabled(fpu_enabled),
      .ll_set(ll_set), .remote_store(remote_store),
      .ext_event(ext_event), .wb(wb), .exc(exc),
      .link_reservation_flag(link_reservation_flag), .addr(addr),
      .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
      .rd_data(rd_data), .irq(irq));

   always #10 clk = ~clk;

   task chk(input logic [63:0] got, input logic [63:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   // results of the taken edge are read just after that same edge
   task issue(input logic [31:0] w, input logic [1:0] sl);
      @(posedge clk);
      instr.valid <= 1'b1;
      instr.word <= w;
      {instr.delay_slot, instr.forbidden_slot} <= sl;
      @(posedge clk);
      instr.valid <= 1'b0;
      #1;
   endtask

   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      wr_en <= 1'b1;
      addr <= a;
      wr_data <= d;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask

   task rd(input logic [3:0] a);
      @(posedge clk);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      rv = rd_data;
   endtask

   // one-cycle pulse on ll_set, remote_store, ext_event
   task pulse(input logic [2:0] b);
      @(posedge clk);
      {ll_set, remote_store, ext_event} <= b;
      @(posedge clk);
      {ll_set, remote_store, ext_event} <= 3'h0;
      #1;
   endtask

   function logic [31:0] mw(input logic [5:0] f);
      return {OPC_FPCOP, FMT_PS, 5'h02, 5'h04, 5'h09, f};
   endfunction

   task end_sim;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task t_regs;
      rd(ADR_CTRL);
      chk(rv, 32'h0000_0009);
      rd(ADR_MASK);
      chk(rv, 32'h0000_0000);
      rd(4'h2);
      chk(rv, 32'h0000_0000);
      wr(ADR_MASK, 32'h0000_0001);
      rd(ADR_MASK);
      chk(rv, 32'h0000_0001);
   endtask

   // high immediate bit catches sign extension
   task t_ori;
      issue(ORI_W, 2'h0);
      chk(wb.gpr_we, 1'b1);
      chk(wb.gpr_idx, 5'h07);
      chk(wb.gpr_data, 64'hf0f0_0000_0000_9235);
      chk(exc.valid, 1'b0);
   endtask

   task t_merge;
      issue(mw(FN_MRG_LL), 2'h0);
      chk(wb.fpr_data, 64'h3333_4444_7777_8888);
      chk(wb.fpr_idx, 5'h09);
      issue(mw(FN_MRG_LU), 2'h0);
      chk(wb.fpr_data, 64'h3333_4444_5555_6666);
      chk(exc.valid, 1'b0);
      @(posedge clk);
      fpu_enabled <= 1'b0;
      issue(mw(FN_MRG_LL), 2'h0);
      chk(exc.valid, 1'b1);
      chk(exc.code, EXC_COP_UNU);
      chk(wb.fpr_we, 1'b0);
      @(posedge clk);
      fpu_enabled <= 1'b1;
      #1;
      chk(irq, 1'b0);
      wr(ADR_CTRL, 32'h0000_0001);
      issue(mw(FN_MRG_LU), 2'h0);
      chk(exc.code, EXC_RESV);
      @(posedge clk);
      #1;
      chk(irq, 1'b1);
      rd(ADR_STAT);
      chk(rv, 32'h0000_0003);
      chk(irq, 1'b0);
      wr(ADR_CTRL, 32'h0000_0009);
   endtask

   // wait entry, an ignored instruction, an optional wake, then release
   task t_spin(input logic [31:0] c, input logic [1:0] sl,
               input logic st1, input logic ev, input logic st2);
      wr(ADR_CTRL, c);
      pulse(3'h4);
      chk(link_reservation_flag, 1'b1);
      issue(SPIN_W, sl);
      chk(issue_stall, st1);
      chk(exc.valid, sl != 2'h0);
      rd(ADR_STATE);
      chk(rv, {30'h000_0000, 1'b1, st1});
      issue(ORI_W, 2'h0);
      chk(wb.gpr_we, !st1);
      pulse({2'h0, ev});
      chk(issue_stall, st2);
      pulse(3'h2);
      chk(issue_stall, 1'b0);
      chk(link_reservation_flag, 1'b0);
      rd(ADR_STAT);
      chk(rv, {28'h000_0000, st1, st1, 1'b0, sl != 2'h0});
   endtask

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      instr = '0;
      instr.rs_val = 64'hf0f0_0000_0000_1234;
      instr.fs_val = 64'h1111_2222_3333_4444;
      instr.ft_val = 64'h5555_6666_7777_8888;
      fpu_enabled = 1'b1;
      {ll_set, remote_store, ext_event} = 3'h0;
      {wr_en, rd_en} = 2'h0;
      addr = 4'h0;
      wr_data = 32'h0000_0000;
      n_mismatch = 0;
      num_checks = 0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_regs;
      t_ori;
      t_merge;
      t_spin(32'h0000_0008, 2'h0, 0, 0, 0);
      t_spin(32'h0000_0009, 2'h0, 1, 0, 1);
      t_spin(32'h0000_0009, 2'h0, 1, 1, 0);
      t_spin(32'h0000_000d, 2'h0, 1, 1, 1);
      t_spin(32'h0000_000b, 2'h2, 0, 0, 0);
      t_spin(32'h0000_000b, 2'h1, 0, 0, 0);
      end_sim;
   end
endmodule
